/* File: design/prsib_bank.v */
`timescale 1ns/1ns
`include "prsib_map.vh"

// What this block does
// - Status bit 7 mirrors whether the regulated output is on.
// - Status bit 2 flags overheat or low thermistor; requests end-of-power packet.
// - Status bit 1 flags rectifier over-voltage in 12V mode; requests end packet.
// - Status bit 0 flags current limit exceeded; requests end packet.
// - Event bit 7 sets whenever the output on state changes.
// - Event bit 2 sets on over-temperature.
// - Event bit 1 sets on rectifier over-voltage.
// - Event bit 0 sets on over-current.
// - Interrupt pin goes low when an event bit and its enable are both 1.
// - Enable bit 7 is writable, resets to 0, gates output-change event.
// - Enable bits 1 and 0 are writable, reset to 1, gate their events.
// - Enable bit 2 is read-only, fixed at 1.
// - Minor firmware revision: low byte 0x0006, high byte 0x0007, read-only.
// - Writing 1 to command bit 5 at 0x004E clears events except still-active ones, releasing the pin unless one of those is enabled.
// - I2C slave at 0x61 with two-byte register address, high byte first.
module prsib_bank (
  input wire clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_n,
  output reg int_out_n,
  input wire output_on,
  input wire overheat_in,
  input wire thermistor_low,
  input wire rect_above_20v,
  input wire out_mode_12v,
  input wire overcurrent_in,
  output reg end_power_transfer_packet
);

  // ----------------------------------------
  // Bus states
  // ----------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_DEVADDR = 3'd1;
  localparam S_ADDR_HI = 3'd2;
  localparam S_ADDR_LO = 3'd3;
  localparam S_WDATA = 3'd4;
  localparam S_RDATA = 3'd5;
  localparam S_IGNORE = 3'd6;

  reg scl_q;
  reg sda_q;
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg ack_phase_q;
  reg rw_q;
  reg [15:0] addr_q;
  reg [7:0] rd_byte_q;
  reg out_on_q;
  reg [7:0] events_q;
  reg [7:0] enables_q;
  reg [7:0] cond_q;
  reg clear_q;
  reg wr_en;
  reg [7:0] rd_mux;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [7:0] shift_next;
  wire [7:0] set_vec;
  wire heat_src;
  wire rect_ov_src;
  wire fault_any;
  wire [15:0] fw_rev;

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;
  assign shift_next = {shift_q[6:0], sda_in};

  // Fault groupings shared by status, packet request and events
  assign heat_src = overheat_in | thermistor_low;
  // Over-voltage only counts in 12V output mode
  assign rect_ov_src = rect_above_20v & out_mode_12v;
  // Any fault asks for the end-of-power packet
  assign fault_any = heat_src | rect_ov_src | overcurrent_in;
  // Revision constant, split into bytes by part-select at the read mux
  assign fw_rev = `PRSIB_FW_MINOR_RST;

  // ----------------------------------------
  // Condition status and packet request
  // ----------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      cond_q <= `PRSIB_SPARE_RST;
      out_on_q <= 1'b0;
      end_power_transfer_packet <= 1'b0;
    end else begin
      cond_q[`PRSIB_OUT_ON_BIT] <= output_on;
      cond_q[`PRSIB_OVERHEAT_BIT] <= heat_src;
      cond_q[`PRSIB_RECT_OV_BIT] <= rect_ov_src;
      cond_q[`PRSIB_OVERCURRENT_BIT] <= overcurrent_in;
      out_on_q <= output_on;
      end_power_transfer_packet <= fault_any;
    end
  end

  // Event sources, one per latched flag; either edge of the output state counts
  assign set_vec = {output_on ^ out_on_q, 4'h0, heat_src, rect_ov_src, overcurrent_in};

  // ----------------------------------------
  // Event flags, enables and pin
  // ----------------------------------------
  // Latched event flags; a source active during a clear keeps its flag
  always @(posedge clk) begin
    if (!reset_n) begin
      events_q <= 8'h00;
    end else begin
      if (clear_q) begin
        events_q <= set_vec;
      end else begin
        events_q <= events_q | set_vec;
      end
    end
  end

  // Enable register; only bits 7, 1 and 0 take written data
  always @(posedge clk) begin
    if (!reset_n) begin
      enables_q <= `PRSIB_EVENT_EN_RST;
    end else begin
      if (wr_en && addr_q == `PRSIB_EVENT_EN_OFS) begin
        enables_q <= (shift_next & `PRSIB_EVENT_EN_WMASK) | `PRSIB_EVENT_EN_FIXED;
      end
    end
  end

  // Interrupt pin; during a clear only still active enabled sources hold it low
  always @(posedge clk) begin
    if (!reset_n) begin
      int_out_n <= 1'b1;
    end else begin
      int_out_n <= ~(|((clear_q ? set_vec : events_q) & enables_q));
    end
  end

  // Read data selection
  always @* begin
    case (addr_q)
      `PRSIB_FW_MINOR_LOW_OFS: rd_mux = fw_rev[7:0];
      `PRSIB_FW_MINOR_HIGH_OFS: rd_mux = fw_rev[15:8];
      `PRSIB_COND_STATUS_OFS: rd_mux = cond_q;
      `PRSIB_EVENT_FLAGS_OFS: rd_mux = events_q;
      `PRSIB_EVENT_EN_OFS: rd_mux = enables_q;
      default: rd_mux = `PRSIB_SPARE_RST;
    endcase
  end

  // ----------------------------------------
  // Bus line sampling
  // ----------------------------------------
  // Reset to the idle high level so no false edge follows reset
  always @(posedge clk) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // ----------------------------------------
  // I2C slave
  // ----------------------------------------
  // Bits are taken on SCL rise; SDA is driven one clock after SCL fall,
  // so the line never moves while SCL is high except for start and stop.
  // The register address auto-increments after each data byte.
  always @(posedge clk) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_phase_q <= 1'b0;
      rw_q <= 1'b0;
      addr_q <= 16'h0000;
      rd_byte_q <= 8'h00;
      sda_oe_n <= 1'b1;
      clear_q <= 1'b0;
    end else begin
      clear_q <= 1'b0;
      if (start_cond) begin
        state_q <= S_DEVADDR;
        bit_cnt_q <= 4'h0;
        ack_phase_q <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state_q <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise && !ack_phase_q && state_q != S_IDLE) begin
        shift_q <= shift_next;
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (wr_en && addr_q == `PRSIB_COMMAND_OFS) begin
          clear_q <= shift_next[`PRSIB_CLEAR_INT_BIT];
        end
      end else if (scl_rise && ack_phase_q && state_q == S_RDATA) begin
        if (sda_in) begin
          state_q <= S_IGNORE; // Master NACK ends read
        end
      end else if (scl_fall) begin
        if (ack_phase_q) begin
          ack_phase_q <= 1'b0;
          bit_cnt_q <= 4'h0;
          sda_oe_n <= 1'b1;
          if (state_q == S_RDATA) begin
            sda_oe_n <= rd_mux[7];
            rd_byte_q <= {rd_mux[6:0], 1'b1};
            addr_q <= addr_q + 16'h0001;
          end
        end else if (state_q == S_RDATA && bit_cnt_q != 4'h8) begin
          sda_oe_n <= rd_byte_q[7];
          rd_byte_q <= {rd_byte_q[6:0], 1'b1};
        end else if (bit_cnt_q == 4'h8) begin
          ack_phase_q <= 1'b1;
          sda_oe_n <= 1'b0;
          case (state_q)
            S_DEVADDR: begin
              if (shift_q[7:1] != `PRSIB_SLAVE_ADDR) begin
                state_q <= S_IGNORE;
                sda_oe_n <= 1'b1;
              end else if (shift_q[0]) begin
                // Read address matched: acknowledge, data follows
                state_q <= S_RDATA;
              end else begin
                state_q <= S_ADDR_HI;
              end
              rw_q <= shift_q[0];
            end
            S_ADDR_HI: begin
              addr_q[15:8] <= shift_q;
              state_q <= S_ADDR_LO;
            end
            S_ADDR_LO: begin
              addr_q[7:0] <= shift_q;
              state_q <= S_WDATA;
            end
            S_WDATA: addr_q <= addr_q + 16'h0001;
            S_RDATA: sda_oe_n <= 1'b1;
            default: sda_oe_n <= 1'b1;
          endcase
        end
      end
    end
  end

  // Write strobe on the last data bit of a write byte
  always @* begin
    wr_en = scl_rise && !ack_phase_q && state_q == S_WDATA && bit_cnt_q == 4'h7 && !rw_q;
  end

endmodule

/* File: design/prsib_map.vh */
`ifndef PRSIB_MAP_VH
`define PRSIB_MAP_VH

// ----------------------------------------
// Slave address and register offsets
// ----------------------------------------
`define PRSIB_SLAVE_ADDR 7'h61
`define PRSIB_FW_MINOR_LOW_OFS 16'h0006
`define PRSIB_FW_MINOR_HIGH_OFS 16'h0007
`define PRSIB_COND_STATUS_OFS 16'h0034
`define PRSIB_COND_SPARE_OFS 16'h0035
`define PRSIB_EVENT_FLAGS_OFS 16'h0036
`define PRSIB_EVENT_SPARE_OFS 16'h0037
`define PRSIB_EVENT_EN_OFS 16'h0038
`define PRSIB_EVENT_EN_SPARE_OFS 16'h0039
`define PRSIB_COMMAND_OFS 16'h004E

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PRSIB_OUT_ON_BIT 7
`define PRSIB_OVERHEAT_BIT 2
`define PRSIB_RECT_OV_BIT 1
`define PRSIB_OVERCURRENT_BIT 0
`define PRSIB_CLEAR_INT_BIT 5

// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define PRSIB_EVENT_EN_RST 8'h1F
`define PRSIB_EVENT_EN_FIXED 8'h1C
`define PRSIB_EVENT_EN_WMASK 8'h83
`define PRSIB_SPARE_RST 8'h00
// Firmware revision is arbitrary
`define PRSIB_FW_MINOR_RST 16'h0102

`endif

/* File: dv/power_rx_status_interrupt_bank_bench.sv */
`timescale 1ns/1ns
// ----------
// Bench top
// ----------
module power_rx_status_interrupt_bank_bench;
  localparam [23:0] FV = {6'h10, 6'h08, 6'h06, 6'h01};
  localparam [31:0] FS = {8'h04, 8'h04, 8'h02, 8'h01};
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [5:0] cond = 6'h00;
  reg [7:0] q;
  reg ak;
  integer n_mismatch = 0;
  integer compares = 0;
  wire scl, sda_out, sda_oe_n, int_out_n, pkt;
  wire sda = sda_out & sda_oe_n;
  // 25 MHz clock
  always #20 clk = ~clk;
  prsib_bank DUT (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_oe_n(sda_oe_n), .int_out_n(int_out_n), .output_on(cond[5]), .thermistor_low(cond[4]),
    .overheat_in(cond[3]), .rect_above_20v(cond[2]), .out_mode_12v(cond[1]),
    .overcurrent_in(cond[0]), .end_power_transfer_packet(pkt));
  prsib_host host (.clk(clk), .sda(sda), .scl(scl), .sda_out(sda_out));
  task check(input string name, input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      host.access(7'h61, a, 1'b1, 8'h00, q, ak);
      check("register", q, e);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    host.access(7'h61, a, 1'b0, d, q, ak);
  endtask
  task set(input [5:0] v);
    begin
      @(negedge clk);
      cond = v;
      repeat (4) @(negedge clk);
    end
  endtask
  task t_reset;
    begin
      rd(16'h0038, 8'h1F);
      rd(16'h0006, 8'h02);
      rd(16'h0036, 8'h00);
      rd(16'h0100, 8'h00);
      wr(16'h0039, 8'hFF);
      rd(16'h0039, 8'h00);
      wr(16'h0007, 8'hFF);
      rd(16'h0007, 8'h01);
      host.access(7'h62, 16'h0034, 1'b1, 8'h00, q, ak);
      check("ack", ak, 1'b0);
    end
  endtask
  task t_output;
    begin
      wr(16'h0038, 8'hFF);
      rd(16'h0038, 8'h9F);
      set(6'h20);
      rd(16'h0034, 8'h80);
      rd(16'h0036, 8'h80);
      check("int", int_out_n, 1'b0);
      wr(16'h0038, 8'h00);
      check("int", int_out_n, 1'b1);
      set(6'h00);
      rd(16'h0034, 8'h00);
    end
  endtask
  task t_faults;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(16'h004E, 8'h20);
        rd(16'h0036, 8'h00);
        set(FV[i*6 +: 6]);
        check("pkt", pkt, 1'b1);
        rd(16'h0034, FS[i*8 +: 8]);
        set(6'h00);
        rd(16'h0036, FS[i*8 +: 8]);
        check("int", int_out_n, !FS[i*8+2]);
      end
      wr(16'h004E, 8'h20);
      check("int", int_out_n, 1'b1);
      wr(16'h0038, 8'h03);
      set(6'h01);
      set(6'h04);
      check("int", int_out_n, 1'b0);
      check("pkt", pkt, 1'b0);
    end
  endtask
  task print_verdict;
    begin
      if (n_mismatch == 0 && compares > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset;
    t_output;
    t_faults;
    print_verdict;
  end
  // Watchdog
  initial begin
    #3000000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
endmodule

/* File: dv/prsib_host.sv */
`timescale 1ns/1ns
// ----------
// Processor side I2C master
// ----------
module prsib_host (
  input wire clk,
  input wire sda,
  output reg scl = 1'b1,
  output reg sda_out = 1'b1
);
  // One bit: SDA moves mid low phase, sampled at end of 4 clock high phase
  task bit_io(input reg b, output reg r);
    begin
      repeat (2) @(negedge clk);
      sda_out = b;
      repeat (2) @(negedge clk);
      scl = 1'b1;
      repeat (4) @(negedge clk);
      r = sda;
      scl = 1'b0;
    end
  endtask
  reg r0;
  // Start or repeated start: SDA falls while SCL stands high
  task start;
    begin
      repeat (2) @(negedge clk);
      sda_out = 1'b1;
      repeat (2) @(negedge clk);
      scl = 1'b1;
      repeat (4) @(negedge clk);
      sda_out = 1'b0;
      repeat (4) @(negedge clk);
      scl = 1'b0;
    end
  endtask
  // Byte out, MSB first, then the ninth acknowledge bit
  task xfer(input reg [7:0] d, output reg [7:0] q, output reg ak);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], q[i]);
      end
      bit_io(1'b1, ak);
    end
  endtask
  // Full access with two address bytes, high first
  task access(input reg [6:0] dev, input reg [15:0] a, input reg rd, input reg [7:0] wd,
    output reg [7:0] q, output reg ack);
    begin
      start;
      xfer({dev, 1'b0}, q, r0);
      ack = !r0;
      xfer(a[15:8], q, r0);
      xfer(a[7:0], q, r0);
      if (rd) begin
        start;
        xfer({dev, 1'b1}, q, r0);
        xfer(8'hFF, q, r0);
      end else begin
        xfer(wd, q, r0);
      end
      // Stop: SDA low under low SCL, then SCL high, then SDA rises
      repeat (2) @(negedge clk);
      sda_out = 1'b0;
      repeat (2) @(negedge clk);
      scl = 1'b1;
      repeat (4) @(negedge clk);
      sda_out = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule

/* File: dv/prsib_props.sv */
`timescale 1ns/1ns
// ----------
// Port checks
// ----------
module prsib_props (
  input wire clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe_n,
  input wire int_out_n,
  input wire output_on,
  input wire overheat_in,
  input wire thermistor_low,
  input wire rect_above_20v,
  input wire out_mode_12v,
  input wire overcurrent_in,
  input wire end_power_transfer_packet
);
  // Fault groupings seen at the condition inputs
  wire heat = overheat_in || thermistor_low;
  wire ovp = rect_above_20v && out_mode_12v;
  wire fault = heat || ovp || overcurrent_in;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  pkt_heat_a: assert property (heat |-> ##[1:2] end_power_transfer_packet)
    else $error("end packet missing on overheat");
  pkt_ovp_a: assert property (ovp |-> ##[1:2] end_power_transfer_packet)
    else $error("end packet missing on overvoltage");
  pkt_oc_a: assert property (overcurrent_in |-> ##[1:2] end_power_transfer_packet)
    else $error("end packet missing on overcurrent");
  pkt_idle_a: assert property ((!fault) [*3] |-> !end_power_transfer_packet)
    else $error("end packet without fault");
  heat_pin_a: assert property (overheat_in |-> ##[1:3] !int_out_n)
    else $error("overheat did not reach pin");
  pin_latch_a: assert property ((scl_in && sda_in) [*8] |-> !$rose(int_out_n))
    else $error("pin released on idle bus");
  sda_drive_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda changed while scl high");
  reset_out_a: assert property ($rose(reset_n) |-> sda_oe_n && int_out_n)
    else $error("outputs active after reset");
  cover property ($fell(int_out_n));
  cover property ($rose(int_out_n));
  cover property ($fell(sda_oe_n));
endmodule

bind prsib_bank prsib_props u_props (.clk(clk), .reset_n(reset_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_n(sda_oe_n), .int_out_n(int_out_n), .output_on(output_on),
  .overheat_in(overheat_in), .thermistor_low(thermistor_low), .rect_above_20v(rect_above_20v),
  .out_mode_12v(out_mode_12v), .overcurrent_in(overcurrent_in),
  .end_power_transfer_packet(end_power_transfer_packet));
